// [shared/aip_defs.vh]
/*
  constants shared by the converter result port: bus framing, result
  word layout, configuration word layout and reset values.
  assumes inclusion by bare name from the design files under verilog/.
*/
`ifndef AIP_DEFS_VH
`define AIP_DEFS_VH

// ----------------------------------------------------------------
// bus framing
// ----------------------------------------------------------------
`define AIP_BYTE_BITS 4'h8
`define AIP_RES_BYTES 5'h18
`define AIP_WR_BYTES 2'h2
`define AIP_ADDR_BASE 7'h14
`define AIP_STRAP_WAIT 2'h3

// ----------------------------------------------------------------
// result word
// ----------------------------------------------------------------
`define AIP_RES_W 24
`define AIP_RES_RST 24'h000000
`define AIP_OVER_WORD 24'hc00000
`define AIP_UNDER_WORD 24'h3fffc0
`define AIP_PAD_ZERO 6'h00

// ----------------------------------------------------------------
// configuration word and its queue
// ----------------------------------------------------------------
`define AIP_CFG_W 16
`define AIP_CFG_RST 16'h0000
`define AIP_EN_PAT 3'h5
`define AIP_EN2_BIT 7
`define AIP_FIFO_W 9
`define AIP_FIFO_D 16

`endif

// [sim/adc_i2c_result_port_test.sv]
/* bench for the result port: master model on the wire, behavioural
   converter core on the other side, straps redrawn at each reset.
   assumes the checker binds itself to the port. */
`timescale 1ns/1ns
`include "aip_defs.vh"
module adc_i2c_result_port_test;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] ca0_code = 2'h0, ca1_code = 2'h0;
  reg conv_done = 1'b0, conv_over = 1'b0, conv_under = 1'b0;
  reg cfg_ready = 1'b0;
  reg [16:0] conv_value = 17'h00000;
  reg started = 1'b0; // a launch not yet answered by the core
  reg [15:0] seed = 16'h4bda;
  reg [6:0] own;
  reg [23:0] word, d;
  reg [15:0] b;
  reg [7:0] rx;
  reg a;
  integer mismatches = 0, tests_run = 0, it, k;
  wire scl_in, sda_pull, sda_out, sda_oe_n, conv_start, conv_busy, cfg_valid;
  wire [8:0] cfg_data;
  wire [15:0] cfg_word;
  wire [23:0] result_word;
  wire sda_in = sda_pull & (sda_oe_n | sda_out); // pull-up when free

  aip_i2c_port aip_i2c_port_inst (.ref_clk, .rst, .scl_in, .sda_in, .sda_out,
    .sda_oe_n, .ca0_code, .ca1_code, .conv_start, .conv_busy, .conv_done,
    .conv_value, .conv_over, .conv_under, .cfg_valid, .cfg_data, .cfg_ready,
    .cfg_word, .result_word);
  aip_bus_master mst (.scl(scl_in), .sda_pull(sda_pull), .sda(sda_in));

  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
  begin
    seed <= lfsr(seed);
    cfg_ready <= seed[3]; // the core stalls the queue at random
  end
  always @(posedge ref_clk)
    if (conv_start)
      started <= 1'b1;

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [23:0] fmt(input [16:0] v, input ov, input un);
    fmt = ov ? 24'hc00000 : un ? 24'h3fffc0 : {~v[16], v, 6'h00};
  endfunction

  task check(input [23:0] seen, input [23:0] exp, input [8*20-1:0] name);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("BAD %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task sel(input [6:0] ad, input rw, input ea);
  begin
    mst.start;
    mst.xfer({ad, rw}, 1'b1, rx, a);
    check(a, ea, "address ack");
  end
  endtask
  task rd(input integer nb);
    integer j;
  begin
    d = 24'h000000;
    sel(own, 1'b1, 1'b0);
    for (j = 0; j < nb; j = j + 1)
    begin
      mst.xfer(8'hff, j == nb - 1, rx, a);
      d = {d[15:0], rx};
    end
  end
  endtask
  // wait for a launch, then answer it like the converter core
  task conv(input [16:0] v, input ov, input un);
    integer n;
  begin
    n = 0;
    while (!started && n < 5000)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    check(started, 1'b1, "launch wait");
    if (!started)
      print_verdict;
    started = 1'b0;
    repeat (20) @(negedge ref_clk);
    check(conv_busy, 1'b1, "busy");
    {conv_value, conv_over, conv_under} = {v, ov, un};
    conv_done = 1'b1;
    word = fmt(v, ov, un);
    @(negedge ref_clk);
    conv_done = 1'b0;
    check(result_word, word, "result");
    check(conv_busy, 1'b0, "idle");
  end
  endtask

  initial
  begin
    for (it = 0; it < 2; it = it + 1)
    begin
      rst = 1'b1;
      ca0_code = seed[1:0] % 2'h3;
      ca1_code = seed[3:2] % 2'h3;
      mst.slow = it;
      repeat (12) @(negedge ref_clk);
      started = 1'b0;
      rst = 1'b0;
      own = `AIP_ADDR_BASE + 7'h3 * ca1_code + ca0_code;
      repeat (6) @(negedge ref_clk);
      check(cfg_word, 16'h0000, "cfg reset");
      check(result_word, 24'h000000, "result reset");
      sel(own, 1'b1, 1'b1);
      mst.stop;
      conv({seed[0], seed}, 1'b0, 1'b0);
      for (k = 0; k < 4; k = k + 1)
      begin
        sel(own ^ 7'h40, 1'b1, 1'b1);
        rd(3);
        check(d, word, "read word");
        sel(own, 1'b1, 1'b1);
        mst.stop;
        conv(k == 3 ? 17'h0ffff : {seed[0], seed}, k == 1, k == 2);
      end
      rd(1);
      mst.stop;
      check(d, {16'h0000, word[23:16]}, "partial read");
      conv({seed[0], seed}, 1'b0, 1'b0);
      b = {3'h5, seed[4:0], (it == 0), seed[12:6]};
      sel(own, 1'b0, 1'b0);
      for (k = 0; k < 3; k = k + 1)
      begin
        mst.xfer(b[15:8], 1'b1, rx, a);
        check(a, k == 2, "write ack");
        b = {b[7:0], b[15:8]};
      end
      rd(3);
      mst.stop;
      check(d, word, "read after write");
      conv({seed[0], seed}, 1'b1, 1'b0);
      check(cfg_word, {b[7:0], (it == 0) ? b[15:8] : 8'h00},
        "cfg word");
    end
    print_verdict;
  end
endmodule

// [sim/aip_bus_master.sv]
/* bus master model: frames, clocks and samples the two-wire bus.
   assumes calls begin on a falling system clock edge, 20 ns grid. */
`timescale 1ns/1ns
module aip_bus_master (
  output reg scl = 1'b1, // serial clock, high between frames
  output reg sda_pull = 1'b1, // low sinks the data wire
  input wire sda // resolved data wire
);
  integer slow = 0; // data set late in the low phase, 20 ns steps
  // the wire moves a step after scl falls, never in the same instant
  task start;
  begin
    #20 sda_pull = 1'b1;
    #20 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40 scl = 1'b0;
  end
  endtask
  task stop;
  begin
    #20 sda_pull = 1'b0;
    #20 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40;
  end
  endtask
  task slot(input b, output s);
  begin
    #(20 + 20 * slow) sda_pull = b;
    #(60 - 20 * slow) scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  end
  endtask
  // eight data slots then the acknowledge slot
  task xfer(input [7:0] tx, input ai, output [7:0] rx, output a);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      slot(tx[i], rx[i]);
    slot(ai, a);
  end
  endtask
endmodule

// [sim/aip_port_chk_asserts.sv]
/* assertions on the result port pins: wire timing, conversion
   handshake, result layout, configuration load.
   assumes binding into every aip_i2c_port. */
`timescale 1ns/1ns
module aip_port_chk (
  input wire ref_clk, // system clock
  input wire rst, // async reset
  input wire scl_in, // serial clock
  input wire sda_out, // data pin value
  input wire sda_oe_n, // low while sinking
  input wire conv_start, // launch pulse
  input wire conv_busy, // converting
  input wire conv_done, // core done
  input wire [16:0] conv_value, // core code
  input wire conv_over, // over range
  input wire conv_under, // under range
  input wire cfg_valid, // queue head valid
  input wire [8:0] cfg_data, // queue head
  input wire cfg_ready, // core pops
  input wire [15:0] cfg_word, // input register
  input wire [23:0] result_word // output register
);
  reg [2:0] lo_q; // clocks since the serial clock went low, saturating
  always @(posedge ref_clk or posedge rst)
    if (rst)
      lo_q <= 3'h0;
    else if (scl_in)
      lo_q <= 3'h0;
    else if (lo_q != 3'h7)
      lo_q <= lo_q + 3'h1;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence fin_s;
    conv_busy && conv_done;
  endsequence
  sequence pop_s;
    cfg_valid && cfg_ready && cfg_data[8:5] == 4'h5;
  endsequence

  a_sink_only: assert property (!sda_out)
    else $error("data pin driven high");
  a_pin_timing: assert property ($changed(sda_oe_n) |->
    lo_q >= 3'h2 && lo_q <= 3'h4) else $error("data moved off clock low");
  a_busy_quiet: assert property (conv_busy [*8] |-> sda_oe_n)
    else $error("data sunk while converting");
  a_start_pulse: assert property (conv_start |=> !conv_start && conv_busy)
    else $error("launch pulse wrong");
  a_done_idle: assert property (fin_s |=> !conv_busy)
    else $error("busy after done");
  a_result_fmt: assert property (fin_s ##0 (!conv_over && !conv_under) |=>
    result_word[22:0] == {$past(conv_value), 6'h00} &&
    result_word[23] != result_word[22]) else $error("result layout wrong");
  a_clamp_over: assert property (fin_s ##0 conv_over |=>
    result_word == 24'hc00000) else $error("over clamp wrong");
  a_clamp_under: assert property (fin_s ##0 (conv_under && !conv_over) |=>
    result_word == 24'h3fffc0) else $error("under clamp wrong");
  a_result_hold: assert property (!(conv_busy && conv_done) |=>
    $stable(result_word)) else $error("result changed while idle");
  a_boot_conv: assert property ($fell(rst) |-> ##[0:2] conv_start)
    else $error("no conversion after reset");
  a_cfg_load: assert property (pop_s |=>
    {1'b0, cfg_word[15:8]} == $past(cfg_data)) else $error("cfg byte lost");
endmodule

bind aip_i2c_port aip_port_chk aip_port_chk_inst (.ref_clk, .rst, .scl_in,
  .sda_out, .sda_oe_n, .conv_start, .conv_busy, .conv_done, .conv_value,
  .conv_over, .conv_under, .cfg_valid, .cfg_data, .cfg_ready, .cfg_word,
  .result_word);

// [verilog/aip_fifo.v]
/*
  synchronous fifo with valid/ready on both sides; storage in flops.
  assumes one clock and an asynchronous active high reset.
*/
`timescale 1ns/1ns
module aip_fifo #(
  parameter W = 9,
  parameter D = 16,
  parameter AW = 4
) (
  input wire ref_clk, // system clock
  input wire rst, // async reset, active high
  input wire in_valid, // write request
  input wire [W-1:0] in_data, // write data
  output wire in_ready, // space left
  output wire out_valid, // data available
  output reg [W-1:0] out_data, // head word
  input wire out_ready // consumer takes head
);

  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @*
  begin
    out_data = mem_q[rp_q];
  end

  always @(posedge ref_clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

// [verilog/aip_i2c_port.v]
/*
  two-wire slave result port of a delta-sigma converter: start/stop
  detection, address match, result read-out, configuration write and
  conversion sequencing.
  assumes scl/sda arrive asynchronously and are oversampled by ref_clk;
  the converter core sits on ref_clk and drains the configuration queue.
*/
// Behaviour
// - repeated start acts as start, bus stays busy
// - each unit is eight bits plus acknowledge
// - ninth clock: transmitter releases, receiver acknowledges
// - data changes only while clock low
// - first byte is address plus direction bit
// - answer only own strapped address, nine choices
// - refuse address while converting, acknowledge after
// - idle after conversion, hold result until addressed
// - read acknowledged, then up to three bytes
// - full read starts conversion, refuse until done
// - 24 bits out, msb first, on falling edges
// - first bit is the sign flag
// - sign flag and next bit encode range
// - sixteen code bits, six trailing zeros
// - out of range results clamp
// - 24-bit result and 16-bit input register
// - only sink data line, clock always input
// - works up to 400 kbit/s
// - stop after write or partial read converts
// - configuration written as two bytes
// - reset default configuration for first conversion
`timescale 1ns/1ns
`include "aip_defs.vh"
module aip_i2c_port #(
  parameter FIFO_D = `AIP_FIFO_D,
  parameter FIFO_AW = 4
) (
  input wire ref_clk, // 50 mhz system clock
  input wire rst, // async reset, active high
  input wire scl_in, // serial clock pin level
  input wire sda_in, // serial data pin level
  output wire sda_out, // data pin output value
  output wire sda_oe_n, // low while pulling data low
  input wire [1:0] ca0_code, // strap 0: 0 low 1 high 2 open
  input wire [1:0] ca1_code, // strap 1: 0 low 1 high 2 open
  output reg conv_start, // pulse: begin a conversion
  output wire conv_busy, // conversion pending or running
  input wire conv_done, // pulse: result ready
  input wire [16:0] conv_value, // signed result code
  input wire conv_over, // over range flag
  input wire conv_under, // under range flag
  output wire cfg_valid, // queued configuration byte
  output wire [8:0] cfg_data, // {second byte flag, byte}
  input wire cfg_ready, // core takes the byte
  output reg [15:0] cfg_word, // input register
  output reg [23:0] result_word // output register
);

  localparam ST_IDLE = 8'h01;
  localparam ST_ADDR = 8'h02;
  localparam ST_AACK = 8'h04;
  localparam ST_WR = 8'h08;
  localparam ST_WACK = 8'h10;
  localparam ST_RD = 8'h20;
  localparam ST_RACK = 8'h40;
  localparam ST_HOLD = 8'h80;

  // --------------------------------------------------------------
  // address table: nine strap combinations
  // --------------------------------------------------------------
  function [6:0] addr_of;
    input [1:0] c1;
    input [1:0] c0;
    reg [1:0] a;
    reg [1:0] b;
    begin
      a = (c1 == 2'h3) ? 2'h2 : c1;
      b = (c0 == 2'h3) ? 2'h2 : c0;
      addr_of = `AIP_ADDR_BASE + {4'h0, a, 1'b0} + {5'h00, a}
        + {5'h00, b};
    end
  endfunction

  reg [1:0] scl_m_q;
  reg [1:0] sda_m_q;
  reg scl_p_q;
  reg sda_p_q;
  reg [3:0] strap_m_q;
  reg [3:0] strap_s_q;
  reg [1:0] cap_cnt_q;
  reg [6:0] my_addr_q;
  reg [7:0] st_q;
  reg [7:0] rx_q;
  reg [3:0] rx_cnt_q;
  reg [4:0] tx_cnt_q;
  reg [23:0] tx_q;
  reg drv_q;
  reg rw_q;
  reg mack_q;
  reg [1:0] wr_idx_q;
  reg wrote_q;
  reg rd_part_q;
  reg pend_q;
  reg conv_run_q;
  reg push_q;
  reg [8:0] push_data_q;
  reg en1_q;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;
  wire fifo_in_ready;
  wire [23:0] fmt_word;
  wire [7:0] rx_byte;

  assign scl_s = scl_m_q[1];
  assign sda_s = sda_m_q[1];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_q;
  assign conv_busy = pend_q | conv_run_q;
  assign rx_byte = {rx_q[6:0], sda_s};

  // --------------------------------------------------------------
  // pin synchronisers and strap capture after reset release
  // --------------------------------------------------------------
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_m_q <= 4'h0;
      strap_s_q <= 4'h0;
      cap_cnt_q <= 2'h0;
      my_addr_q <= 7'h00;
    end
    else
    begin
      scl_m_q <= {scl_m_q[0], scl_in};
      sda_m_q <= {sda_m_q[0], sda_in};
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      strap_m_q <= {ca1_code, ca0_code};
      strap_s_q <= strap_m_q;
      if (cap_cnt_q != `AIP_STRAP_WAIT)
        cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == 2'h2)
        my_addr_q <= addr_of(strap_s_q[3:2], strap_s_q[1:0]);
    end
  end

  // --------------------------------------------------------------
  // bus state machine
  // --------------------------------------------------------------
  // oversampling at 50 mhz leaves over 60 clocks per scl phase at
  // 400 kbit/s, so edges are seen well apart from data changes
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      rx_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      tx_cnt_q <= 5'h00;
      tx_q <= `AIP_RES_RST;
      drv_q <= 1'b0;
      rw_q <= 1'b0;
      mack_q <= 1'b1;
      wr_idx_q <= 2'h0;
      wrote_q <= 1'b0;
      rd_part_q <= 1'b0;
      pend_q <= 1'b1;
      conv_run_q <= 1'b0;
      conv_start <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 9'h000;
    end
    else
    begin
      conv_start <= 1'b0;
      push_q <= 1'b0;
      if (pend_q & ~conv_run_q & ~cfg_valid)
      begin
        // queued configuration must reach the core first
        pend_q <= 1'b0;
        conv_run_q <= 1'b1;
        conv_start <= 1'b1;
      end
      else if (conv_done & conv_run_q)
        conv_run_q <= 1'b0;
      if (stop_ev)
      begin
        st_q <= ST_IDLE;
        drv_q <= 1'b0;
        if ((wrote_q | rd_part_q) & ~conv_busy)
          pend_q <= 1'b1;
        wrote_q <= 1'b0;
        rd_part_q <= 1'b0;
      end
      else if (start_ev)
      begin
        st_q <= ST_ADDR;
        drv_q <= 1'b0;
        rx_cnt_q <= 4'h0;
      end
      else if (scl_rise)
      begin
        if (st_q == ST_ADDR || st_q == ST_WR)
        begin
          rx_q <= rx_byte;
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
        if (st_q == ST_RACK)
          mack_q <= sda_s;
      end
      else if (scl_fall)
      begin
        case (st_q)
          ST_ADDR:
          begin
            if (rx_cnt_q == `AIP_BYTE_BITS)
            begin
              rw_q <= rx_q[0];
              if (rx_q[7:1] == my_addr_q && ~conv_busy)
              begin
                drv_q <= 1'b1;
                st_q <= ST_AACK;
              end
              else
                st_q <= ST_HOLD;
            end
          end
          ST_AACK:
          begin
            rx_cnt_q <= 4'h0;
            wr_idx_q <= 2'h0;
            if (rw_q)
            begin
              drv_q <= ~result_word[23];
              tx_q <= {result_word[22:0], 1'b0};
              tx_cnt_q <= 5'h01;
              rd_part_q <= 1'b1;
              st_q <= ST_RD;
            end
            else
            begin
              drv_q <= 1'b0;
              wrote_q <= 1'b1;
              st_q <= ST_WR;
            end
          end
          ST_WR:
          begin
            if (rx_cnt_q == `AIP_BYTE_BITS)
            begin
              if (wr_idx_q != `AIP_WR_BYTES && fifo_in_ready)
              begin
                push_q <= 1'b1;
                push_data_q <= {wr_idx_q[0], rx_q};
                wr_idx_q <= wr_idx_q + 2'h1;
                drv_q <= 1'b1;
                st_q <= ST_WACK;
              end
              else
                st_q <= ST_HOLD;
            end
          end
          ST_WACK:
          begin
            drv_q <= 1'b0;
            rx_cnt_q <= 4'h0;
            st_q <= ST_WR;
          end
          ST_RD:
          begin
            if (tx_cnt_q[2:0] == 3'h0)
            begin
              drv_q <= 1'b0;
              st_q <= ST_RACK;
              if (tx_cnt_q == `AIP_RES_BYTES)
              begin
                rd_part_q <= 1'b0;
                if (~conv_busy)
                  pend_q <= 1'b1;
              end
            end
            else
            begin
              drv_q <= ~tx_q[23];
              tx_q <= {tx_q[22:0], 1'b0};
              tx_cnt_q <= tx_cnt_q + 5'h01;
            end
          end
          ST_RACK:
          begin
            if (mack_q || tx_cnt_q == `AIP_RES_BYTES)
            begin
              drv_q <= 1'b0;
              st_q <= ST_HOLD;
            end
            else
            begin
              drv_q <= ~tx_q[23];
              tx_q <= {tx_q[22:0], 1'b0};
              tx_cnt_q <= tx_cnt_q + 5'h01;
              st_q <= ST_RD;
            end
          end
          ST_IDLE, ST_HOLD:
            drv_q <= 1'b0;
          default:
          begin
            drv_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // output register and input register
  // --------------------------------------------------------------
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      result_word <= `AIP_RES_RST;
      cfg_word <= `AIP_CFG_RST;
      en1_q <= 1'b0;
    end
    else
    begin
      if (conv_done & conv_run_q)
        result_word <= fmt_word;
      if (cfg_valid & cfg_ready)
      begin
        if (~cfg_data[8])
        begin
          en1_q <= (cfg_data[7:5] == `AIP_EN_PAT);
          if (cfg_data[7:5] == `AIP_EN_PAT)
            cfg_word[15:8] <= cfg_data[7:0];
        end
        else if (en1_q & cfg_data[`AIP_EN2_BIT])
          cfg_word[7:0] <= cfg_data[7:0];
      end
    end
  end

  aip_result_fmt u_fmt (
    .conv_value(conv_value),
    .conv_over(conv_over),
    .conv_under(conv_under),
    .word(fmt_word)
  );

  // core stalling on cfg_ready fills this; a full queue refuses bytes
  aip_fifo #(
    .W(`AIP_FIFO_W),
    .D(FIFO_D),
    .AW(FIFO_AW)
  ) u_cfg_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push_q),
    .in_data(push_data_q),
    .in_ready(fifo_in_ready),
    .out_valid(cfg_valid),
    .out_data(cfg_data),
    .out_ready(cfg_ready)
  );

endmodule

// [verilog/aip_result_fmt.v]
/*
  builds the 24-bit output word from the converter core's code.
  assumes the core flags over and under range in the same cycle.
*/
`timescale 1ns/1ns
`include "aip_defs.vh"
module aip_result_fmt (
  input wire [16:0] conv_value, // signed in-range code
  input wire conv_over, // input at or above +fs
  input wire conv_under, // input below -fs
  output reg [23:0] word // formatted result
);

  // --------------------------------------------------------------
  // sign flag is the inverse of the code's own sign
  // --------------------------------------------------------------
  always @*
  begin
    if (conv_over)
      word = `AIP_OVER_WORD;
    else if (conv_under)
      word = `AIP_UNDER_WORD;
    else
      word = {~conv_value[16], conv_value, `AIP_PAD_ZERO};
  end

endmodule
